// ==== logic/gear_follow_pkg.sv ====
// package: constants and carriers for the electronic gear follower
package gear_follow_pkg;
    // *************************************************************
    // register map and reset values
    // *************************************************************
    localparam logic [15:0] POS_CHG_MODE_OFFSET = 16'h2616;
    localparam logic [15:0] POS_CHG_MODE_RESET  = 16'h0000;
    localparam logic [31:0] NUM_RESET           = 32'h0000_0001;
    localparam logic [31:0] DENOM_RESET         = 32'h0000_0001;
    localparam int          INCR_PER_REV        = 131072;
    localparam int          POS_W               = 32;

    // synchronisation methods written to start the mode
    typedef enum logic [1:0] {
        SYNC_IMMEDIATE  = 2'h0,
        SYNC_COMPENSATE = 2'h1
    } sync_method_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_RUN     = 3'b010,
        ST_STOPPING = 3'b100
    } gear_state_t;

    typedef struct packed {
        logic a;
        logic b;
    } ref_pins_t;
endpackage

// ==== logic/electronic_gear_reference_follower.sv ====
// electronic gear reference follower: counts reference pulses, scales by gear ratio
// *************************************************************
// Behaviour
// - reference from quadrature or pulse/direction, scaled
// - input type setting selects the decoder
// - sync method write while idle records method, starts mode
// - reference change times ratio moves target while running with power on
// - targets in internal units, followed at once
// - mode ends on deactivate, halt or error standstill
// - one revolution equals 131072 internal increments
// - reference keeps counting while mode interrupted
// - power-off change handling: 0 ignore, 1 compensate
// - handling setting only counts with compensation method
// - signed numerator over positive denominator, sign reverses
// *************************************************************
`timescale 1ns/1ps
module electronic_gear_reference_follower #(
    parameter int POS_W = gear_follow_pkg::POS_W
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire gear_follow_pkg::ref_pins_t ref_pins_i,
    input  wire logic                     reference_input_type_select_i,
    input  wire logic                     sync_wr_i,
    input  wire logic [1:0]               gear_sync_method_start_i,
    input  wire logic                     deactivate_i,
    input  wire logic                     halt_i,
    input  wire logic                     error_i,
    input  wire logic                     motor_standstill_i,
    input  wire logic                     power_enabled_i,
    input  wire logic signed [31:0]       ratio_numerator_i,
    input  wire logic [31:0]              ratio_denominator_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [15:0]              reg_addr_i,
    input  wire logic [15:0]              reg_wdata_i,
    output logic      [15:0]              reg_rdata_o,
    output logic                          gear_active_o,
    output logic      [1:0]               sync_method_o,
    output logic signed [POS_W-1:0]       ref_count_o,
    output logic signed [POS_W-1:0]       target_pos_o
);
    // narrower counts wrap within one revolution; wider ones outgrow the product
    if (POS_W < 18 || POS_W > 48) begin : g_pos_w_check
        $error("POS_W out of range");
    end

    localparam int RES_W = POS_W + 32;

    // *************************************************************
    // pin synchronisers
    // *************************************************************
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] prev_ff;
    logic [1:0] nxt_sync1;
    logic [1:0] nxt_sync2;
    logic [1:0] nxt_prev;
    // pins are asynchronous: the second stage and its one-cycle-delayed copy feed the decoder
    always_comb begin
        nxt_sync1 = {ref_pins_i.a, ref_pins_i.b};
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
            prev_ff  <= 2'h0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
        end
    end

    // *************************************************************
    // reference decoder
    // *************************************************************
    logic       step;
    logic       step_up;
    logic       qa;
    logic       qb;
    logic       pa;
    logic       pb;
    always_comb begin
        qa = sync2_ff[1];
        qb = sync2_ff[0];
        pa = prev_ff[1];
        pb = prev_ff[0];
        step    = 1'b0;
        step_up = 1'b0;
        if (reference_input_type_select_i) begin
            // pulse on a, direction level on b at rising edge
            step    = qa & ~pa;
            step_up = ~qb;
        end else begin
            // any single-phase change is a quadrature count
            step    = (qa ^ pa) ^ (qb ^ pb);
            step_up = qa ^ pb;
        end
    end

    // *************************************************************
    // parameter register
    // *************************************************************
    logic [15:0] chg_mode_ff;
    logic [15:0] nxt_chg_mode;

    // one decode shared by the write and the read path
    function automatic logic addr_hit(
        input logic [15:0] addr
    );
        return addr == gear_follow_pkg::POS_CHG_MODE_OFFSET;
    endfunction

    always_comb begin
        nxt_chg_mode = chg_mode_ff;
        if (reg_wr_i && addr_hit(reg_addr_i)) begin
            nxt_chg_mode = {15'h0000, reg_wdata_i[0]};
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chg_mode_ff <= gear_follow_pkg::POS_CHG_MODE_RESET;
        end else begin
            chg_mode_ff <= nxt_chg_mode;
        end
    end
    always_comb begin
        reg_rdata_o = 16'h0000;
        if (reg_rd_i && addr_hit(reg_addr_i)) begin
            reg_rdata_o = chg_mode_ff;
        end
    end

    // *************************************************************
    // mode control and position
    // *************************************************************
    gear_follow_pkg::gear_state_t state_ff;
    gear_follow_pkg::gear_state_t nxt_state;
    logic [1:0]             method_ff;
    logic [1:0]             nxt_method;
    logic signed [POS_W-1:0] count_ff;
    logic signed [POS_W-1:0] nxt_count;
    logic signed [POS_W-1:0] base_ff;
    logic signed [POS_W-1:0] nxt_base;
    logic signed [POS_W-1:0] anchor_ff;
    logic signed [POS_W-1:0] nxt_anchor;
    logic signed [POS_W-1:0] target_ff;
    logic signed [POS_W-1:0] nxt_target;
    logic signed [POS_W-1:0] delta;
    logic                   compensate;

    // scale reference delta; combinational divide trades area for zero latency
    function automatic logic signed [POS_W-1:0] scale(
        input logic signed [POS_W-1:0] d,
        input logic signed [31:0]      num,
        input logic        [31:0]      den
    );
        logic signed [RES_W-1:0] p;
        logic signed [RES_W-1:0] q;
        p = RES_W'(d) * RES_W'(num);
        q = (den == 32'h0) ? p : p / $signed({{(RES_W-32){1'b0}}, den});
        return q[POS_W-1:0];
    endfunction

    always_comb begin
        nxt_state  = state_ff;
        nxt_method = method_ff;
        nxt_count  = count_ff;
        nxt_base   = base_ff;
        nxt_anchor = anchor_ff;
        nxt_target = target_ff;
        compensate = (method_ff == 2'(gear_follow_pkg::SYNC_COMPENSATE))
                     && chg_mode_ff[0];
        if (step) begin
            nxt_count = step_up ? count_ff + 1'b1 : count_ff - 1'b1;
        end
        delta = nxt_count - anchor_ff;
        unique case (state_ff)
            gear_follow_pkg::ST_IDLE: begin
                if (sync_wr_i) begin
                    nxt_method = gear_sync_method_start_i;
                    nxt_state  = gear_follow_pkg::ST_RUN;
                    nxt_anchor = nxt_count;
                    nxt_base   = target_ff;
                end
            end
            gear_follow_pkg::ST_RUN: begin
                if (!power_enabled_i && !compensate) begin
                    // ignored changes: re-anchor so they never reach the motor
                    nxt_anchor = nxt_count;
                    nxt_base   = target_ff;
                end else if (power_enabled_i) begin
                    // target in 1/131072 rev increments, follows every change
                    nxt_target = base_ff + scale(delta, ratio_numerator_i,
                                                 ratio_denominator_i);
                end
                if (halt_i || error_i || deactivate_i) begin
                    nxt_state = gear_follow_pkg::ST_STOPPING;
                end
            end
            gear_follow_pkg::ST_STOPPING: begin
                if (motor_standstill_i) begin
                    nxt_state = gear_follow_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = gear_follow_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff    <= gear_follow_pkg::ST_IDLE;
            method_ff   <= 2'h0;
            count_ff    <= '0;
            base_ff     <= '0;
            anchor_ff   <= '0;
            target_ff   <= '0;
        end else begin
            state_ff    <= nxt_state;
            method_ff   <= nxt_method;
            count_ff    <= nxt_count;
            base_ff     <= nxt_base;
            anchor_ff   <= nxt_anchor;
            target_ff   <= nxt_target;
        end
    end

    assign gear_active_o = (state_ff != gear_follow_pkg::ST_IDLE);
    assign sync_method_o = method_ff;
    assign ref_count_o   = count_ff;
    assign target_pos_o  = target_ff;
endmodule

// ==== testbench/gear_ref_src.sv ====
// partner model: external controller that issues reference increments
`timescale 1ns/1ps
module gear_ref_src (
    input  wire logic                  clk_i,
    input  wire logic                  pulse_mode_i,
    output gear_follow_pkg::ref_pins_t pins_o
);
    logic [1:0] phase;
    // **********
    // stepping
    // **********
    initial begin
        phase = 2'h0;
        pins_o = '0;
    end
    // pins held 4+ cycles: slower than the 2-stage input synchroniser
    task automatic step(input logic down);
        @(negedge clk_i);
        if (pulse_mode_i) begin
            pins_o.b = down;
            repeat (2) @(negedge clk_i);
            pins_o.a = 1'b1;
            repeat (4) @(negedge clk_i);
            pins_o.a = 1'b0;
        end else begin
            phase = down ? phase - 2'h1 : phase + 2'h1;
            pins_o = '{a: phase[1] ^ phase[0], b: phase[1]};
        end
        repeat (4) @(negedge clk_i);
    endtask
endmodule

// ==== testbench/gear_follow_chk.sv ====
// checker: port properties of the gear follower
`timescale 1ns/1ps
module gear_follow_chk #(
    parameter int POS_W = 32
) (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    sync_wr_i,
    input wire logic [1:0]              gear_sync_method_start_i,
    input wire logic                    deactivate_i,
    input wire logic                    motor_standstill_i,
    input wire logic                    reg_rd_i,
    input wire logic [15:0]             reg_addr_i,
    input wire logic [15:0]             reg_rdata_o,
    input wire logic                    gear_active_o,
    input wire logic [1:0]              sync_method_o,
    input wire logic signed [POS_W-1:0] ref_count_o,
    input wire logic signed [POS_W-1:0] target_pos_o
);
    // **********
    // properties
    // **********
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire idle_wr = sync_wr_i && !gear_active_o;
    start_a: assert property (idle_wr |=> gear_active_o) else $error("no start");
    method_rec_a: assert property (idle_wr
        |=> sync_method_o == $past(gear_sync_method_start_i)) else $error("method lost");
    refuse_a: assert property (sync_wr_i && gear_active_o |=> $stable(sync_method_o))
        else $error("restart taken");
    reg_bits_a: assert property (reg_rd_i && reg_addr_i == 16'h2616
        |-> reg_rdata_o[15:1] == 15'h0) else $error("upper bits set");
    unmapped_a: assert property (reg_rd_i && reg_addr_i != 16'h2616
        |-> reg_rdata_o == 16'h0) else $error("unmapped data");
    mode_end_a: assert property ((deactivate_i && motor_standstill_i && !sync_wr_i) [*3]
        |=> !gear_active_o) else $error("no end");
    count_step_a: assert property ($changed(ref_count_o)
        |-> ref_count_o - $past(ref_count_o) inside {1, -1}) else $error("count jump");
    idle_hold_a: assert property (!gear_active_o ##1 !gear_active_o
        |-> $stable(target_pos_o)) else $error("target moved");
    cover property (idle_wr);
    cover property ($fell(gear_active_o));
    cover property (gear_active_o && $changed(target_pos_o));
endmodule
bind electronic_gear_reference_follower gear_follow_chk #(.POS_W(POS_W)) i_gear_follow_chk (.*);

// ==== testbench/tb_electronic_gear_reference_follower.sv ====
// testbench: register access, mode control and reference following
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("Error %0t %h %h", $time, (a), (e)); end end
module tb_electronic_gear_reference_follower;
    logic                       clk_i, rst_i, sel, swr, still, pwr, rwr, rrd, act;
    logic [1:0]                 meth, smeth;
    logic [2:0]                 stop;
    logic [15:0]                addr, wdata, rdata;
    logic signed [31:0]         num, cnt, tgt;
    logic [31:0]                den;
    gear_follow_pkg::ref_pins_t pins;
    int                         checked, n_fail;
    electronic_gear_reference_follower i_electronic_gear_reference_follower (
        .clk_i(clk_i), .rst_i(rst_i), .ref_pins_i(pins), .reference_input_type_select_i(sel),
        .sync_wr_i(swr), .gear_sync_method_start_i(meth), .deactivate_i(stop[2]),
        .halt_i(stop[1]), .error_i(stop[0]), .motor_standstill_i(still), .power_enabled_i(pwr),
        .ratio_numerator_i(num), .ratio_denominator_i(den), .reg_wr_i(rwr), .reg_rd_i(rrd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .gear_active_o(act),
        .sync_method_o(smeth), .ref_count_o(cnt), .target_pos_o(tgt));
    gear_ref_src i_gear_ref_src (.clk_i(clk_i), .pulse_mode_i(sel), .pins_o(pins));
    // **********
    // access tasks
    // **********
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_i);
        {rwr, addr, wdata} = {1'b1, a, d};
        @(negedge clk_i);
        rwr = 1'b0;
    endtask
    // read data is combinational, so it is looked at inside the strobe cycle
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(negedge clk_i);
        {rrd, addr} = {1'b1, a};
        #1 `CHK(rdata, e)
        @(negedge clk_i);
        rrd = 1'b0;
    endtask
    task automatic go(input logic [1:0] m);
        @(negedge clk_i);
        {swr, meth} = {1'b1, m};
        @(negedge clk_i);
        swr = 1'b0;
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // whole run is under two hundred cycles
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
    initial begin
        rst_i = 1'b1;
        {sel, swr, meth, stop, still, rwr, rrd, addr, wdata} = '0;
        {pwr, num, den} = {1'b1, 32'sh3, 32'h2};
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        rd(16'h2616, 16'h0);
        wr(16'h2616, 16'hffff);
        wr(16'h2615, 16'h0);
        rd(16'h2616, 16'h1);
        rd(16'h2617, 16'h0);
        go(2'h1);
        `CHK({act, smeth}, 3'h5)
        repeat (4) i_gear_ref_src.step(1'b0);
        `CHK({cnt, tgt}, {32'h4, 32'h6})
        i_gear_ref_src.step(1'b1);
        `CHK({cnt, tgt}, {32'h3, 32'h4})
        go(2'h0);
        `CHK(smeth, 2'h1)
        pwr = 1'b0;
        repeat (2) i_gear_ref_src.step(1'b0);
        `CHK({cnt, tgt}, {32'h5, 32'h4})
        pwr = 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK(tgt, 32'h7)
        wr(16'h2616, 16'h0);
        pwr = 1'b0;
        repeat (2) i_gear_ref_src.step(1'b0);
        pwr = 1'b1;
        repeat (2) @(negedge clk_i);
        `CHK({cnt, tgt}, {32'h7, 32'h7})
        i_gear_ref_src.step(1'b0);
        `CHK(tgt, 32'h8)
        for (int i = 0; i < 3; i++) begin
            go(2'h0);
            stop = 3'h1 << i;
            repeat (3) @(negedge clk_i);
            `CHK(act, 1'b1)
            still = 1'b1;
            repeat (3) @(negedge clk_i);
            `CHK(act, 1'b0)
            {stop, still} = 4'h0;
        end
        sel = 1'b1;
        repeat (2) i_gear_ref_src.step(1'b0);
        `CHK({cnt, tgt}, {32'ha, 32'h8})
        num = -32'sh3;
        go(2'h0);
        i_gear_ref_src.step(1'b0);
        `CHK({cnt, tgt}, {32'hb, 32'h7})
        repeat (2) i_gear_ref_src.step(1'b1);
        `CHK({cnt, tgt}, {32'h9, 32'h9})
        den = 32'h1;
        repeat (2) @(negedge clk_i);
        `CHK(tgt, 32'hb)
        den = 32'h0;
        repeat (2) @(negedge clk_i);
        `CHK(tgt, 32'hb)
        give_verdict();
    end
endmodule
